/* File: bench/cft_ctrl_properties.sv */
`timescale 1ns/1ps
// Port-level checks on flush, special cycles and the walker
module cft_ctrl_properties
  import cft_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Flush sources
  input wire logic        flush_n_i,
  input wire logic        invalidate_instr_i,
  input wire logic        writeback_invalidate_instr_i,
  input wire logic        flushing_o,
  input wire logic        exec_stall_o,
  // Cache views
  input wire logic        cache_acc_i,
  input wire logic [1:0]  victim_way_o,
  input wire logic [3:0]  valid_view_o,
  // Translation
  input wire logic        paging_en_i,
  input wire logic [31:0] page_dir_base_reg_i,
  input wire logic        xlat_req_i,
  input wire logic        xlat_busy_o,
  input wire logic        xlat_done_o,
  input wire logic        walk_req_o,
  input wire logic [31:0] walk_addr_o,
  input wire logic        walk_pcd_o,
  input wire logic        walk_alloc_o,
  input wire logic        walk_pwt_o,
  input wire logic        burst_ready_n_i,
  input wire logic [31:0] walk_data_i,
  // Special cycles
  input wire logic        spc_req_o,
  input wire logic [2:0]  spc_cyc_o,
  input wire logic [3:0]  spc_be_n_o,
  input wire logic        spc_done_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic dir_phase_q;

  // High while the next ready of a walk answers the directory read
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dir_phase_q <= 1'b1;
    else if (!walk_req_o)
      dir_phase_q <= 1'b1;
    else if (!burst_ready_n_i)
      dir_phase_q <= 1'b0;
  end

  // Two sampled lows are enough even for an unsynchronised driver
  a_pin_flush: assert property (!flush_n_i ##1 !flush_n_i |-> ##2 flushing_o)
    else $error("pin flush not taken");
  a_held_stall: assert property (!flush_n_i [*3] |=> exec_stall_o)
    else $error("held flush pin did not stall");
  a_flush_clears: assert property (flushing_o && !cache_acc_i |=> valid_view_o == VALID_RESET)
    else $error("valid bits survive a flush");
  a_victim_first: assert property (valid_view_o != 4'hF |-> victim_way_o == (!valid_view_o[0] ? 2'h0 :
    !valid_view_o[1] ? 2'h1 : !valid_view_o[2] ? 2'h2 : 2'h3)) else $error("victim is not first invalid way");
  a_invalidate_instr_cycle: assert property (invalidate_instr_i && !spc_req_o |=> spc_req_o && spc_be_n_o == BE_FLUSH &&
    spc_cyc_o == CYC_SPECIAL) else $error("no flush special cycle");
  a_writeback_invalidate_instr_first: assert property (writeback_invalidate_instr_i && !spc_req_o |=>
    spc_req_o && spc_be_n_o == BE_WRITEBACK) else $error("write-back cycle missing");
  a_wb_then_flush: assert property (spc_req_o && spc_done_i && spc_be_n_o == BE_WRITEBACK |=>
    spc_req_o && spc_be_n_o == BE_FLUSH) else $error("flush cycle not after write-back");
  a_spc_holds: assert property (spc_req_o && !spc_done_i |=> spc_req_o && $stable(spc_be_n_o))
    else $error("special cycle dropped early");
  a_dir_first: assert property ($rose(walk_req_o) |-> walk_addr_o[31:12] == page_dir_base_reg_i[31:12] &&
    walk_pcd_o == page_dir_base_reg_i[ENT_PCD] && walk_alloc_o != page_dir_base_reg_i[ENT_PCD])
    else $error("directory read attributes wrong");
  a_walk_bound: assert property ($rose(walk_req_o) |-> ##[2:40] xlat_done_o)
    else $error("walk never completed");
  a_nopage_pass: assert property (xlat_req_i && !xlat_busy_o && !paging_en_i |->
    !walk_req_o throughout (##[1:3] xlat_done_o)) else $error("unpaged request walked or hung");
  a_tbl_attrs: assert property (walk_req_o && !burst_ready_n_i && dir_phase_q |=> walk_req_o &&
    walk_pcd_o == $past(walk_data_i[ENT_PCD]) && walk_pwt_o == $past(walk_data_i[ENT_PWT]) &&
    walk_alloc_o != $past(walk_data_i[ENT_PCD])) else $error("table read attributes wrong");
endmodule

bind cft_ctrl cft_ctrl_properties u_props (.*);

/* File: bench/cft_partner.sv */
`timescale 1ns/1ps
// Far-side system logic: answers walk reads and special cycles
module cft_partner
  import cft_pkg::*;
(
  // Clock, reset and answer delay
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  slow_i,
  // Walk reads
  input  wire logic        walk_req_i,
  input  wire logic [31:0] walk_addr_i,
  output logic             burst_ready_n_o,
  output logic [31:0]      walk_data_o,
  // Special cycles
  input  wire logic        spc_req_i,
  output logic             spc_done_o
);
  logic [1:0] wcnt_q;
  logic [1:0] scnt_q;

  // Entry is present, frame is the inverted read address, cache bits follow address bits 2 and 3
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      burst_ready_n_o <= 1'b1;
      walk_data_o     <= 32'h0;
      wcnt_q          <= 2'h0;
    end
    else if (walk_req_i && burst_ready_n_o && wcnt_q >= slow_i)
    begin
      burst_ready_n_o <= 1'b0;
      walk_data_o     <= {~walk_addr_i[21:2], 7'h00, walk_addr_i[2], walk_addr_i[3], 3'h1};
      wcnt_q          <= 2'h0;
    end
    else
    begin
      burst_ready_n_o <= 1'b1;
      walk_data_o     <= ~walk_data_o;
      wcnt_q          <= walk_req_i ? wcnt_q + 2'h1 : 2'h0;
    end
  end

  // One done pulse per special cycle, after slow_i idle cycles
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      spc_done_o <= 1'b0;
      scnt_q     <= 2'h0;
    end
    else if (spc_req_i && !spc_done_o && scnt_q >= slow_i)
    begin
      spc_done_o <= 1'b1;
      scnt_q     <= 2'h0;
    end
    else
    begin
      spc_done_o <= 1'b0;
      scnt_q     <= spc_req_i ? scnt_q + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the flush controller and walker
module tb_top
  import cft_pkg::*;
;
  logic        mclk_i, rst_n_i, flush_n_i, hold_ack_i, invalidate_instr_i, writeback_invalidate_instr_i;
  logic        cache_acc_i, cache_fill_i, paging_en_i, xlat_req_i, burst_ready_n_i, spc_done_i;
  logic        xlat_busy_o, xlat_done_o, phys_pcd_o, phys_pwt_o, walk_req_o, walk_pcd_o, walk_pwt_o;
  logic        walk_alloc_o, spc_req_o, flushing_o, exec_stall_o;
  logic [6:0]  cache_set_i, victim_set_i, s;
  logic [1:0]  cache_way_i, victim_way_o, slow;
  logic [2:0]  spc_cyc_o, lru;
  logic [3:0]  spc_be_n_o, valid_view_o;
  logic [31:0] page_dir_base_reg_i, lin_addr_i, phys_addr_o, walk_addr_o, walk_data_i, lin;
  int          bad_count, total_checks;
  logic [33:0] xq[$];
  logic [33:0] note;
  logic [3:0]  sq[$];

  cft_ctrl DUT (.*);
  cft_partner u_far (.mclk_i, .rst_n_i, .slow_i(slow), .walk_req_i(walk_req_o), .walk_addr_i(walk_addr_o),
    .burst_ready_n_o(burst_ready_n_i), .walk_data_o(walk_data_i), .spc_req_i(spc_req_o), .spc_done_o(spc_done_i));

  // 200 MHz clock
  initial mclk_i = 1'b0;
  always #2.5 mclk_i = ~mclk_i;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task report_and_stop;
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cache access report; the bench keeps its own tree of recency bits
  task automatic acc(input logic [1:0] w, input logic f);
    cache_acc_i = 1'b1;
    cache_set_i = s;
    cache_way_i = w;
    cache_fill_i = f;
    step(1);
    cache_acc_i = 1'b0;
    cache_fill_i = 1'b0;
    // One idle edge, so back-to-back reports never drop and raise the strobe at once
    step(1);
    lru[0] = ~w[1];
    if (!w[1])
      lru[1] = ~w[0];
    else
      lru[2] = ~w[0];
  endtask

  task automatic peek(input logic [3:0] v, input logic [1:0] vw);
    victim_set_i = s;
    step(2);
    chk("valid_view", valid_view_o, v);
    chk("victim", victim_way_o, vw);
  endtask

  // A hit must finish inside the four-way probe, well before any walk could
  task automatic xlat(input logic [31:0] a, input logic [33:0] e, input logic hit);
    int n;
    n = 0;
    xq.push_back(e);
    lin_addr_i = a;
    xlat_req_i = 1'b1;
    step(1);
    xlat_req_i = 1'b0;
    repeat (60)
      if (xlat_done_o !== 1'b1)
      begin
        step(1);
        n++;
      end
    if (hit)
      chk("hit_cycles", {31'h0, n > 6}, 32'h0);
    step(1);
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge mclk_i)
  begin
    if (xlat_done_o === 1'b1)
    begin
      note = xq.pop_front();
      chk("phys_addr", phys_addr_o, note[31:0]);
      chk("phys_attr", {30'h0, phys_pcd_o, phys_pwt_o}, {30'h0, note[33:32]});
    end
    if (spc_req_o === 1'b1 && spc_done_i === 1'b1)
    begin
      chk("spc_be_n", {28'h0, spc_be_n_o}, {28'h0, sq.pop_front()});
      chk("spc_cyc", {29'h0, spc_cyc_o}, {29'h0, CYC_SPECIAL});
    end
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop;
  end

  initial
  begin
    {rst_n_i, hold_ack_i, invalidate_instr_i, writeback_invalidate_instr_i, cache_acc_i, cache_fill_i} = 6'h00;
    {paging_en_i, xlat_req_i, cache_set_i, victim_set_i, cache_way_i, lru, slow} = 23'h0;
    {page_dir_base_reg_i, lin_addr_i} = 64'h0;
    flush_n_i = 1'b1;
    void'($urandom(32'hDBD0));
    step(12);
    rst_n_i = 1'b1;
    step(1);
    chk("be_reset", {28'h0, spc_be_n_o}, 32'hF);
    chk("busy_reset", {31'h0, xlat_busy_o}, 32'h0);
    // Fill a set, then random hits must steer the victim
    s = 7'($urandom_range(127));
    for (int w = 0; w < 4; w++)
      acc(2'(w), 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      peek(4'hF, lru[0] ? {1'b1, lru[2]} : {1'b0, lru[1]});
      acc(2'($urandom_range(3)), 1'b0);
    end
    // Two-clock pin pulse during bus hold, released after the flush
    hold_ack_i = 1'b1;
    flush_n_i = 1'b0;
    step(2);
    flush_n_i = 1'b1;
    step(3);
    hold_ack_i = 1'b0;
    peek(4'h0, 2'h0);
    // Pin held: execution stays stalled until it is let go
    flush_n_i = 1'b0;
    step(6);
    chk("stall_on", {31'h0, exec_stall_o}, 32'h1);
    flush_n_i = 1'b1;
    step(4);
    chk("stall_off", {31'h0, exec_stall_o}, 32'h0);
    // Both instructions clear the cache and signal outside caches
    for (int i = 0; i < 2; i++)
    begin
      acc(2'h0, 1'b1);
      slow = 2'($urandom_range(2));
      if (i == 0)
        sq.push_back(BE_WRITEBACK);
      sq.push_back(BE_FLUSH);
      writeback_invalidate_instr_i = (i == 0);
      invalidate_instr_i = (i == 1);
      step(1);
      {writeback_invalidate_instr_i, invalidate_instr_i} = 2'h0;
      peek(4'h0, 2'h0);
      repeat (40) if (spc_req_o === 1'b1) step(1);
      step(1);
    end
    // Unpaged requests pass straight through
    for (int i = 0; i < 3; i++)
    begin
      page_dir_base_reg_i = $urandom;
      lin = $urandom;
      xlat(lin, {page_dir_base_reg_i[ENT_PCD], page_dir_base_reg_i[ENT_PWT], lin}, 1'b0);
    end
    // Paged requests: a walk, then a hit on the same page
    paging_en_i = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      page_dir_base_reg_i = $urandom;
      slow = 2'($urandom_range(2));
      lin = $urandom;
      xlat(lin, {lin[12], lin[13], lin[31:22], ~lin[21:12], lin[11:0]}, 1'b0);
      xlat(lin, {lin[12], lin[13], lin[31:22], ~lin[21:12], lin[11:0]}, 1'b1);
    end
    step(2);
    chk("pending", xq.size() + sq.size(), 32'h0);
    report_and_stop;
  end
endmodule

/* File: rtl/cft_ctrl.sv */
`timescale 1ns/1ps
// Cache flush control and translation buffer refresh walker
module cft_ctrl
  import cft_pkg::*;
#(
  parameter int unsigned ENTRIES = TLB_ENTRIES
)
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // External flush pin and bus hold
  input  wire logic        flush_n_i,
  input  wire logic        hold_ack_i,
  // Instruction flush requests (one-cycle pulses)
  input  wire logic        invalidate_instr_i,
  input  wire logic        writeback_invalidate_instr_i,
  // Cache access reports for LRU update
  input  wire logic        cache_acc_i,
  input  wire logic [6:0]  cache_set_i,
  input  wire logic [1:0]  cache_way_i,
  input  wire logic        cache_fill_i,
  // Victim query
  input  wire logic [6:0]  victim_set_i,
  output logic [1:0]       victim_way_o,
  // Paging control
  input  wire logic        paging_en_i,
  input  wire logic [31:0] page_dir_base_reg_i,
  // Internal translation request
  input  wire logic        xlat_req_i,
  input  wire logic [31:0] lin_addr_i,
  output logic             xlat_busy_o,
  output logic             xlat_done_o,
  output logic [31:0]      phys_addr_o,
  output logic             phys_pcd_o,
  output logic             phys_pwt_o,
  // Walk reads on the external bus
  output logic             walk_req_o,
  output logic [31:0]      walk_addr_o,
  output logic             walk_pcd_o,
  output logic             walk_pwt_o,
  output logic             walk_alloc_o,
  input  wire logic        burst_ready_n_i,
  input  wire logic [31:0] walk_data_i,
  // Special cycle out
  output logic             spc_req_o,
  output logic [2:0]       spc_cyc_o,
  output logic [3:0]       spc_be_n_o,
  input  wire logic        spc_done_i,
  // Cache state views
  output logic             flushing_o,
  output logic             exec_stall_o,
  output logic [3:0]       valid_view_o
);
  typedef enum logic [2:0] {W_IDLE, W_LOOK, W_DIR, W_TBL, W_DONE} cft_walk_e;

  logic               flush_sync_n;
  logic [3:0]         valid_q   [CACHE_SETS];
  logic [2:0]         lru_q     [CACHE_SETS];
  logic               instr_flush;
  logic               do_flush;
  cft_special_e       spc_q;
  cft_walk_e          walk_q;
  logic [ENTRIES-1:0] tvld_q;
  logic [2:0]         tlru_q    [TLB_SETS];
  logic [31:0]        lin_q;
  logic               mem_we;
  logic [4:0]         mem_waddr;
  logic [41:0]        mem_wdata;
  logic [4:0]         mem_raddr;
  logic [41:0]        mem_rdata;
  logic [2:0]         tset;
  logic [1:0]         tway;
  logic [1:0]         tvict;
  logic               thit;
  logic [1:0]         rway_q;
  logic               look_q;

  cft_sync u_sync (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .din_n_i  (flush_n_i),
    .dout_n_o (flush_sync_n)
  );

  // Storage word: {linear page tag, frame, cache disable, write-through}; hits drive the table's own bits
  cft_tlb_mem #(.DEPTH(ENTRIES), .AW(5), .DW(42)) u_mem (
    .mclk_i  (mclk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // Hold acknowledge does not gate flush, so it is accepted in hold too
  assign instr_flush = invalidate_instr_i | writeback_invalidate_instr_i;
  assign do_flush    = ~flush_sync_n | instr_flush;

  // Valid bits: single-cycle clear of all sets on flush
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < CACHE_SETS; i++)
        valid_q[i] <= VALID_RESET;
    end
    else if (do_flush)
    begin
      for (int i = 0; i < CACHE_SETS; i++)
        valid_q[i] <= VALID_RESET;
    end
    else if (cache_acc_i && cache_fill_i)
      valid_q[cache_set_i][cache_way_i] <= 1'b1;
  end

  // LRU tree bits, cleared with the valid bits
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < CACHE_SETS; i++)
        lru_q[i] <= LRU_RESET;
    end
    else if (do_flush)
    begin
      for (int i = 0; i < CACHE_SETS; i++)
        lru_q[i] <= LRU_RESET;
    end
    else if (cache_acc_i)
      lru_q[cache_set_i] <= cft_lru_next(lru_q[cache_set_i], cache_way_i);
  end

  // Registered victim and state views
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      victim_way_o <= 2'h0;
      valid_view_o <= 4'h0;
      flushing_o   <= 1'b0;
      exec_stall_o <= 1'b0;
    end
    else
    begin
      victim_way_o <= cft_victim(valid_q[victim_set_i], lru_q[victim_set_i]);
      valid_view_o <= valid_q[victim_set_i];
      flushing_o   <= do_flush;
      exec_stall_o <= ~flush_sync_n;
    end
  end

  // Special cycle announcing the flush to external caches
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      spc_q      <= SC_NONE;
      spc_req_o  <= 1'b0;
      spc_cyc_o  <= CYC_IDLE;
      spc_be_n_o <= 4'hF;
    end
    else if (spc_q == SC_NONE)
    begin
      if (writeback_invalidate_instr_i)
      begin
        spc_q      <= SC_WB;
        spc_req_o  <= 1'b1;
        spc_cyc_o  <= CYC_SPECIAL;
        spc_be_n_o <= BE_WRITEBACK;
      end
      else if (invalidate_instr_i)
      begin
        spc_q      <= SC_FLUSH;
        spc_req_o  <= 1'b1;
        spc_cyc_o  <= CYC_SPECIAL;
        spc_be_n_o <= BE_FLUSH;
      end
    end
    else if (spc_done_i)
    begin
      if (spc_q == SC_WB)
      begin
        spc_q      <= SC_FLUSH;
        spc_be_n_o <= BE_FLUSH; // Write back first, then flush
      end
      else
      begin
        spc_q      <= SC_NONE;
        spc_req_o  <= 1'b0;
        spc_cyc_o  <= CYC_IDLE;
        spc_be_n_o <= 4'hF;
      end
    end
  end

  // Buffer addressing: 8 sets of 4 ways indexed by low linear page bits
  assign tset      = lin_q[LIN_TBL_LSB +: TLB_SET_AW];
  assign mem_raddr = {tset, tway};
  assign tvict     = cft_victim({tvld_q[{tset, 2'h3}], tvld_q[{tset, 2'h2}],
                                 tvld_q[{tset, 2'h1}], tvld_q[{tset, 2'h0}]}, tlru_q[tset]);
  assign thit      = look_q && tvld_q[{tset, rway_q}] && (mem_rdata[41:22] == lin_q[31:12]);
  assign mem_we    = (walk_q == W_TBL) && !burst_ready_n_i;
  assign mem_waddr = {tset, tvict};
  assign mem_wdata = {lin_q[31:12], walk_data_i[31:12], walk_data_i[ENT_PCD], walk_data_i[ENT_PWT]};

  // Refresh walker; a probe scans the four ways of the set one per cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      walk_q       <= W_IDLE;
      tway         <= 2'h0;
      lin_q        <= 32'h0;
      xlat_busy_o  <= 1'b0;
      xlat_done_o  <= 1'b0;
      phys_addr_o  <= 32'h0;
      phys_pcd_o   <= 1'b0;
      phys_pwt_o   <= 1'b0;
      walk_req_o   <= 1'b0;
      walk_addr_o  <= 32'h0;
      walk_pcd_o   <= 1'b0;
      walk_pwt_o   <= 1'b0;
      walk_alloc_o <= 1'b0;
    end
    else
    begin
      xlat_done_o <= 1'b0;
      unique case (walk_q)
        W_IDLE:
          if (xlat_req_i)
          begin
            lin_q       <= lin_addr_i;
            xlat_busy_o <= 1'b1;
            tway        <= 2'h0;
            if (paging_en_i)
              walk_q <= W_LOOK;
            else
            begin
              phys_addr_o <= lin_addr_i;
              phys_pcd_o  <= page_dir_base_reg_i[ENT_PCD];
              phys_pwt_o  <= page_dir_base_reg_i[ENT_PWT];
              walk_q      <= W_DONE;
            end
          end
        W_LOOK:
          // Read data lags the address by one cycle, so judge the way read on the last edge
          if (thit)
          begin
            phys_addr_o <= {mem_rdata[21:2], lin_q[11:0]};
            phys_pcd_o  <= mem_rdata[1];
            phys_pwt_o  <= mem_rdata[0];
            walk_q      <= W_DONE;
          end
          else if (look_q && rway_q == 2'h3)
          begin
            walk_req_o   <= 1'b1;
            walk_addr_o  <= {page_dir_base_reg_i[31:12], lin_q[31:22], 2'h0};
            walk_pcd_o   <= page_dir_base_reg_i[ENT_PCD];
            walk_pwt_o   <= page_dir_base_reg_i[ENT_PWT];
            walk_alloc_o <= ~page_dir_base_reg_i[ENT_PCD];
            walk_q       <= W_DIR;
          end
          else if (tway != 2'h3)
            tway <= tway + 2'h1;
        W_DIR:
          if (!burst_ready_n_i)
          begin
            walk_addr_o  <= {walk_data_i[31:12], lin_q[21:12], 2'h0};
            walk_pcd_o   <= walk_data_i[ENT_PCD];
            walk_pwt_o   <= walk_data_i[ENT_PWT];
            walk_alloc_o <= ~walk_data_i[ENT_PCD];
            walk_q       <= W_TBL;
          end
        W_TBL:
          if (!burst_ready_n_i)
          begin
            walk_req_o  <= 1'b0;
            phys_addr_o <= {walk_data_i[31:12], lin_q[11:0]};
            phys_pcd_o  <= walk_data_i[ENT_PCD];
            phys_pwt_o  <= walk_data_i[ENT_PWT];
            walk_q      <= W_DONE;
          end
        W_DONE:
        begin
          xlat_busy_o <= 1'b0;
          xlat_done_o <= 1'b1;
          walk_q      <= W_IDLE;
        end
        default:
          walk_q <= W_IDLE;
      endcase
    end
  end

  // Way of the registered read data, and whether it belongs to the probe now running
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rway_q <= 2'h0;
      look_q <= 1'b0;
    end
    else
    begin
      rway_q <= tway;
      look_q <= (walk_q == W_LOOK); // Stale data from an older lookup never hits
    end
  end

  // Buffer valid and LRU state; paging off leaves it untouched
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tvld_q <= '0;
      for (int i = 0; i < TLB_SETS; i++)
        tlru_q[i] <= LRU_RESET;
    end
    else if (mem_we)
    begin
      tvld_q[mem_waddr] <= 1'b1;
      tlru_q[tset]      <= cft_lru_next(tlru_q[tset], tvict);
    end
    else if (walk_q == W_LOOK && thit)
      tlru_q[tset] <= cft_lru_next(tlru_q[tset], rway_q);
  end
endmodule

/* File: rtl/cft_pkg.sv */
package cft_pkg;
  localparam int unsigned CACHE_SETS    = 128;
  localparam int unsigned SET_AW        = 7;
  localparam int unsigned TLB_ENTRIES   = 32;
  localparam int unsigned TLB_SETS      = 8;
  localparam int unsigned TLB_SET_AW    = 3;
  localparam int unsigned LRU_W         = 3;
  localparam int unsigned WAYS          = 4;
  // LRU tree bit positions
  localparam int unsigned LRU_TOP       = 0;
  localparam int unsigned LRU_LEFT      = 1;
  localparam int unsigned LRU_RIGHT     = 2;
  localparam logic [2:0]  LRU_RESET     = 3'h0;
  localparam logic [3:0]  VALID_RESET   = 4'h0;
  // Entry field positions (32-bit directory or table entry)
  localparam int unsigned ENT_PRESENT   = 0;
  localparam int unsigned ENT_PWT       = 3;
  localparam int unsigned ENT_PCD       = 4;
  localparam int unsigned ENT_FRAME_LSB = 12;
  localparam int unsigned LIN_DIR_LSB   = 22;
  localparam int unsigned LIN_TBL_LSB   = 12;
  // Special cycle byte-enable codes, active low
  localparam logic [3:0]  BE_FLUSH      = 4'hD;
  localparam logic [3:0]  BE_WRITEBACK  = 4'h7;
  // Special cycle definition: M/IO D/C W/R = 0 0 1
  localparam logic [2:0]  CYC_SPECIAL   = 3'h1;
  localparam logic [2:0]  CYC_MEM_READ  = 3'h6;
  localparam logic [2:0]  CYC_IDLE      = 3'h0;
  typedef enum logic [1:0] {SC_NONE, SC_FLUSH, SC_WB} cft_special_e;

  // Next LRU bits after an access to a way
  function automatic logic [2:0] cft_lru_next(input logic [2:0] cur, input logic [1:0] way);
    logic [2:0] n;
    n = cur;
    n[LRU_TOP] = ~way[1];
    if (way[1] == 1'b0)
      n[LRU_LEFT] = ~way[0];
    else
      n[LRU_RIGHT] = ~way[0];
    return n;
  endfunction

  // Victim: first invalid way, else tree walk towards least recent
  function automatic logic [1:0] cft_victim(input logic [3:0] vld, input logic [2:0] lru);
    logic [1:0] v;
    v = 2'h0;
    if (!vld[0])
      v = 2'h0;
    else if (!vld[1])
      v = 2'h1;
    else if (!vld[2])
      v = 2'h2;
    else if (!vld[3])
      v = 2'h3;
    else if (lru[LRU_TOP])
      v = {1'b1, lru[LRU_RIGHT]};
    else
      v = {1'b0, lru[LRU_LEFT]};
    return v;
  endfunction
endpackage

/* File: rtl/cft_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for an active-low level, idles deasserted
module cft_sync
  import cft_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Level
  input  wire logic din_n_i,
  output logic      dout_n_o
);
  logic meta_q;

  // First stage is read only by the second
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q   <= 1'b1;
      dout_n_o <= 1'b1;
    end
    else
    begin
      meta_q   <= din_n_i;
      dout_n_o <= meta_q;
    end
  end
endmodule

/* File: rtl/cft_tlb_mem.sv */
`timescale 1ns/1ps
// Translation buffer storage: tag and frame words, registered read
module cft_tlb_mem
  import cft_pkg::*;
#(
  parameter int unsigned DEPTH = TLB_ENTRIES,
  parameter int unsigned AW    = 5,
  parameter int unsigned DW    = 40
)
(
  // Clock
  input  wire logic          mclk_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  // Storage needs no reset: valid bits live in the controller
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end
endmodule
